// >>> include/hs_pkg.sv
// package: constants, types and states of the hot-swap capability registers
`default_nettype none
package hs_pkg;
    // configuration byte offsets of the register set
    localparam logic [7:0] HS_OFS_PM_DATA      = 8'hE3;
    localparam logic [7:0] HS_OFS_CAP_ID       = 8'hE4;
    localparam logic [7:0] HS_OFS_NEXT_PTR     = 8'hE5;
    localparam logic [7:0] HS_OFS_CTRL_STAT    = 8'hE6;
    // dword addresses (address bits 7:2) holding those bytes
    localparam logic [5:0] HS_DW_PM            = HS_OFS_PM_DATA[7:2];
    localparam logic [5:0] HS_DW_HS            = HS_OFS_CAP_ID[7:2];
    // byte lanes inside the dword
    localparam int         HS_LANE_PM_DATA     = 3;
    localparam int         HS_LANE_CTRL_STAT   = 2;
    localparam int         HS_LANE_CAP_ID      = 0;
    localparam int         HS_LANE_NEXT_PTR    = 1;
    localparam int         HS_LANE_BITS        = 8;
    // constant register contents
    localparam logic [7:0] HS_PM_DATA_VALUE    = 8'h00;
    localparam logic [7:0] HS_CAP_ID_VALUE     = 8'h06;
    localparam logic [7:0] HS_NEXT_PTR_VALUE   = 8'h00;
    localparam logic [1:0] HS_PROG_IF_VALUE    = 2'h1;
    // field positions inside the control/status byte (bit - 16)
    localparam int         HS_BIT_DEV_HIDE     = 0;
    localparam int         HS_BIT_IRQ_MASK     = 1;
    localparam int         HS_BIT_PEND_IE      = 2;
    localparam int         HS_BIT_LED          = 3;
    localparam int         HS_BIT_PROG_IF_LO   = 4;
    localparam int         HS_BIT_PROG_IF_HI   = 5;
    localparam int         HS_BIT_EXTRACT      = 6;
    localparam int         HS_BIT_INSERT       = 7;
    // cycles for the handle synchroniser to deliver a valid level
    localparam logic [1:0] HS_SETTLE_CYCLES    = 2'h2;

    // insertion / extraction sequencer
    typedef enum logic [2:0] {
        HS_ST_SETTLE,
        HS_ST_OPEN,
        HS_ST_INSERT,
        HS_ST_ACTIVE
    } hs_fsm_t;

    // one configuration access from the bridge's primary target logic
    typedef struct packed {
        logic        req;
        logic        write;
        logic [5:0]  dword_addr;
        logic [3:0]  primary_cmd_byte_en_n;
        logic [31:0] wdata;
    } hs_cfg_req_t;

    // answer to a configuration access
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } hs_cfg_rsp_t;

    // whole state of the register block
    typedef struct packed {
        hs_fsm_t     fsm;
        logic [1:0]  settle;
        logic        device_hide_arm;
        logic        enum_irq_mask;
        logic        led_on_off;
        logic        extraction_flag;
        logic        insertion_flag;
        logic        enum_drive;
        hs_cfg_rsp_t rsp;
    } hs_state_t;
endpackage : hs_pkg
`default_nettype wire

// >>> hdl/hs_sync.sv
// two-flop synchroniser for a level arriving from a pin
`default_nettype none
module hs_sync (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic srst,
    // level in and synchronised level out
    input  wire logic pin_level,
    output logic      sync_level
);
    // both stages held as one state word
    typedef struct packed {
        logic meta;
        logic level;
    } hs_sync_t;

    hs_sync_t state;
    hs_sync_t next_state;

    // first stage feeds only the second stage; nothing else reads meta
    always_comb begin
        next_state.meta  = pin_level;
        next_state.level = state.meta;
    end

    // both stages cleared in reset: the level reads open until settled
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // output straight from the second flop
    assign sync_level = state.level;
endmodule : hs_sync
`default_nettype wire

// >>> hdl/hs_cap_regs.sv
// hot-swap capability registers of the bridge configuration space
`default_nettype none

// Functional notes
// - power-management data byte, bits 31:24, always reads zero.
// - capability identifier byte, bits 7:0, always reads 0x06.
// - next-item pointer byte, bits 15:8, always reads 0x00.
// - while device hiding is armed, the bridge claims no bus transaction.
// - hiding arms when reset ends with handle open; clears on insertion.
// - mask bit one stops driving the enumeration pin; zero allows it.
// - pending insertion/extraction bit is read-only and reads zero.
// - software-written LED bit lights or darkens the external indicator.
// - programming-interface field is read-only and reads 01.
// - insertion flag set after handle closed and reset released; drives pin.
module hs_cap_regs (
    // clock and synchronous reset (primary reset)
    input  wire logic              core_clk,
    input  wire logic              srst,
    // configuration access from the primary target logic
    input  wire hs_pkg::hs_cfg_req_t cfg_req,
    output hs_pkg::hs_cfg_rsp_t    cfg_rsp,
    // ejector handle switch, high while the handle is closed
    input  wire logic              handle_closed,
    // enumeration pin, open drain, active low
    input  wire logic              enumeration_irq_n_in,
    output logic                   enumeration_irq_n_out,
    output logic                   enumeration_irq_n_oe,
    // indicator and hiding control toward the rest of the bridge
    output logic                   led_drive,
    output logic                   bridge_hidden
);
    import hs_pkg::*;

    hs_state_t state;
    hs_state_t next_state;
    logic      handle_sync;
    logic      access;
    logic      wr_ctrl;
    logic [7:0] ctrl_wbyte;

    // pin level passes two flops before the sequencer reads it
    hs_sync u_handle_sync (
        .core_clk   (core_clk),
        .srst       (srst),
        .pin_level  (handle_closed),
        .sync_level (handle_sync)
    );

    // the pin input is only observed by the board; nothing here reads it
    logic unused_pin;
    assign unused_pin = enumeration_irq_n_in;

    // place one byte on its lane of a dword
    function automatic logic [31:0] put_lane(input logic [31:0] w,
                                             input int          lane,
                                             input logic [7:0]  b);
        logic [31:0] r;
        r = w;
        r[lane*HS_LANE_BITS +: HS_LANE_BITS] = b;
        return r;
    endfunction : put_lane

    // pick one byte lane out of a dword
    function automatic logic [7:0] lane_byte(input logic [31:0] w,
                                             input int          lane);
        return w[lane*HS_LANE_BITS +: HS_LANE_BITS];
    endfunction : lane_byte

    // assemble the control/status byte as software sees it
    function automatic logic [7:0] ctrl_byte(input hs_state_t s);
        logic [7:0] b;
        b = 8'h00;
        b[HS_BIT_DEV_HIDE]   = s.device_hide_arm;
        b[HS_BIT_IRQ_MASK]   = s.enum_irq_mask;
        b[HS_BIT_PEND_IE]    = 1'b0;
        b[HS_BIT_LED]        = s.led_on_off;
        b[HS_BIT_PROG_IF_LO] = HS_PROG_IF_VALUE[0];
        b[HS_BIT_PROG_IF_HI] = HS_PROG_IF_VALUE[1];
        b[HS_BIT_EXTRACT]    = s.extraction_flag;
        b[HS_BIT_INSERT]     = s.insertion_flag;
        return b;
    endfunction : ctrl_byte

    // read data for one dword address, unowned bytes read as zero
    function automatic logic [31:0] read_dword(input hs_state_t s,
                                               input logic [5:0] dw);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (dw == HS_DW_PM) begin
            d = put_lane(d, HS_LANE_PM_DATA, HS_PM_DATA_VALUE);
        end else if (dw == HS_DW_HS) begin
            d = put_lane(d, HS_LANE_CAP_ID, HS_CAP_ID_VALUE);
            d = put_lane(d, HS_LANE_NEXT_PTR, HS_NEXT_PTR_VALUE);
            d = put_lane(d, HS_LANE_CTRL_STAT, ctrl_byte(s));
        end
        return d;
    endfunction : read_dword

    // a hidden bridge claims nothing, not even its own config space
    function automatic logic takes(input hs_cfg_req_t r,
                                   input hs_state_t   s);
        return r.req && !s.device_hide_arm;
    endfunction : takes

    // control/status byte written: right dword, its lane enabled
    function automatic logic hits_ctrl(input hs_cfg_req_t r);
        logic lane_on;
        lane_on = !r.primary_cmd_byte_en_n[HS_LANE_CTRL_STAT];
        return r.write && (r.dword_addr == HS_DW_HS) && lane_on;
    endfunction : hits_ctrl

    // software write of the control/status byte
    function automatic hs_state_t apply_write(input hs_state_t  s,
                                              input logic [7:0] b);
        hs_state_t n;
        n = s;
        n.device_hide_arm = b[HS_BIT_DEV_HIDE];
        n.enum_irq_mask   = b[HS_BIT_IRQ_MASK];
        n.led_on_off      = b[HS_BIT_LED];
        // a zero leaves the flag alone; a read-modify-write that writes a set flag back clears it
        if (b[HS_BIT_EXTRACT]) begin
            n.extraction_flag = 1'b0;
        end
        if (b[HS_BIT_INSERT]) begin
            n.insertion_flag = 1'b0;
        end
        return n;
    endfunction : apply_write

    // insertion/extraction sequencer, applied after the software write
    // so that its sets win over a clear landing in the same cycle
    function automatic hs_state_t step_seq(input hs_state_t cur,
                                           input hs_state_t nxt,
                                           input logic      closed);
        hs_state_t n;
        n = nxt;
        unique case (cur.fsm)
            HS_ST_SETTLE: begin
                // the synchroniser holds a real handle level only now
                if (cur.settle != HS_SETTLE_CYCLES) begin
                    n.settle = 2'(cur.settle + 2'h1);
                end else if (!closed) begin
                    n.device_hide_arm = 1'b1;
                    n.fsm             = HS_ST_OPEN;
                end else begin
                    n.fsm = HS_ST_INSERT;
                end
            end
            HS_ST_OPEN: begin
                // board waits for its handle to be closed
                if (closed) begin
                    n.fsm = HS_ST_INSERT;
                end
            end
            HS_ST_INSERT: begin
                // handle closed and reset long released
                n.insertion_flag  = 1'b1;
                n.device_hide_arm = 1'b0;
                n.fsm             = HS_ST_ACTIVE;
            end
            HS_ST_ACTIVE: begin
                // handle opening announces a removal
                if (!closed) begin
                    n.extraction_flag = 1'b1;
                    n.fsm             = HS_ST_OPEN;
                end
            end
            default: begin
                // an unused code restarts the handle check
                n.fsm = HS_ST_SETTLE;
            end
        endcase
        return n;
    endfunction : step_seq

    // pin pulls low while a flag stands and the mask is clear
    function automatic logic pin_drive(input hs_state_t s);
        logic flag_up;
        flag_up = s.insertion_flag || s.extraction_flag;
        return flag_up && !s.enum_irq_mask;
    endfunction : pin_drive

    // one-cycle answer; read data from the contents before this edge
    function automatic hs_cfg_rsp_t answer(input hs_state_t   s,
                                           input hs_cfg_req_t r,
                                           input logic        taken);
        hs_cfg_rsp_t a;
        a.ack   = taken;
        a.rdata = 32'h0000_0000;
        if (taken && !r.write) begin
            a.rdata = read_dword(s, r.dword_addr);
        end
        return a;
    endfunction : answer

    // access decode from the contents before this edge
    assign access     = takes(cfg_req, state);
    assign wr_ctrl    = access && hits_ctrl(cfg_req);
    assign ctrl_wbyte = lane_byte(cfg_req.wdata, HS_LANE_CTRL_STAT);

    // next state: software write, then sequencer, then pin and answer
    always_comb begin
        next_state = state;
        if (wr_ctrl) begin
            next_state = apply_write(state, ctrl_wbyte);
        end
        next_state            = step_seq(state, next_state, handle_sync);
        next_state.enum_drive = pin_drive(next_state);
        next_state.rsp        = answer(state, cfg_req, access);
    end

    // single state register, reset to the documented values
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state.fsm             <= HS_ST_SETTLE;
            state.settle          <= 2'h0;
            state.device_hide_arm <= 1'b0;
            state.enum_irq_mask   <= 1'b0;
            state.led_on_off      <= 1'b0;
            state.extraction_flag <= 1'b0;
            state.insertion_flag  <= 1'b0;
            state.enum_drive      <= 1'b0;
            state.rsp             <= '0;
        end else begin
            state <= next_state;
        end
    end

    // outputs come straight from the state flops, except the constant pin level
    assign cfg_rsp               = state.rsp;
    assign enumeration_irq_n_out = 1'b0;            // open drain: only low
    assign enumeration_irq_n_oe  = state.enum_drive;
    assign led_drive             = state.led_on_off;
    assign bridge_hidden         = state.device_hide_arm;
endmodule : hs_cap_regs
`default_nettype wire

// >>> tb/hs_ejector_model.sv
// model of the ejector handle switch and the enumeration line pull-up
`default_nettype none
module hs_ejector_model (
    // handle position commanded by the bench
    input  wire logic open_cmd,
    output logic      handle_closed,
    // open-drain enumeration line
    input  wire logic irq_out,
    input  wire logic irq_oe,
    output logic      irq_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // switch contact, closed unless opened
    assign handle_closed = !open_cmd;
    // a released line floats up to the board pull-up, never the old value
    assign irq_pin = irq_oe ? irq_out : 1'b1;
endmodule : hs_ejector_model
`default_nettype wire

// >>> tb/hs_cap_regs_props.sv
// checker: concurrent properties at the hot-swap register ports
`default_nettype none
module hs_props (
    // clock and reset
    input wire logic                core_clk,
    input wire logic                srst,
    // register access
    input wire hs_pkg::hs_cfg_req_t cfg_req,
    input wire hs_pkg::hs_cfg_rsp_t cfg_rsp,
    // pins
    input wire logic                handle_closed,
    input wire logic                enumeration_irq_n_out,
    input wire logic                enumeration_irq_n_oe,
    input wire logic                led_drive,
    input wire logic                bridge_hidden
);
    import hs_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // accesses that a visible bridge takes
    logic take, rd38, rd39, wr39;
    assign take = cfg_req.req && !bridge_hidden;
    assign rd38 = take && !cfg_req.write && cfg_req.dword_addr == HS_DW_PM;
    assign rd39 = take && !cfg_req.write && cfg_req.dword_addr == HS_DW_HS;
    assign wr39 = take && cfg_req.write && cfg_req.dword_addr == HS_DW_HS
        && !cfg_req.primary_cmd_byte_en_n[HS_LANE_CTRL_STAT];
    // mask as software last left it, to judge the pin
    logic mask_seen;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            mask_seen <= 1'b0;
        end else if (wr39) begin
            mask_seen <= cfg_req.wdata[17];
        end
    end
    property p_pm; rd38 |=> cfg_rsp.rdata[31:24] == 8'h00; endproperty
    a_pm: assert property (p_pm) else $error("pm byte");
    property p_id; rd39 |=> cfg_rsp.rdata[15:0] == 16'h0006; endproperty
    a_id: assert property (p_id) else $error("id bytes");
    property p_ro;
        rd39 |=> cfg_rsp.rdata[21:20] == 2'h1 && !cfg_rsp.rdata[18];
    endproperty
    a_ro: assert property (p_ro) else $error("ro bits");
    property p_hid; bridge_hidden && cfg_req.req |=> !cfg_rsp.ack; endproperty
    a_hid: assert property (p_hid) else $error("hidden ack");
    property p_arm;
        $fell(bridge_hidden) |-> $past(handle_closed, 2);
    endproperty
    a_arm: assert property (p_arm) else $error("arm clear");
    property p_msk; wr39 && cfg_req.wdata[17] |-> ##2 !enumeration_irq_n_oe;
    endproperty
    a_msk: assert property (p_msk) else $error("mask");
    property p_led; wr39 |=> led_drive == $past(cfg_req.wdata[19]); endproperty
    a_led: assert property (p_led) else $error("led");
    property p_od;
        enumeration_irq_n_oe |-> !enumeration_irq_n_out && !mask_seen;
    endproperty
    a_od: assert property (p_od) else $error("pin level");
    property p_ins;
        $fell(bridge_hidden) && !mask_seen |-> enumeration_irq_n_oe;
    endproperty
    a_ins: assert property (p_ins) else $error("insert pin");
    property p_w0;
        wr39 && cfg_req.wdata[23:22] == 2'h0 && !cfg_req.wdata[17]
        && enumeration_irq_n_oe |=> ##1 enumeration_irq_n_oe;
    endproperty
    a_w0: assert property (p_w0) else $error("flag kept");
endmodule : hs_props
`default_nettype wire

// >>> tb/testbench.sv
// testbench: host accesses and handle moves against the hot-swap registers
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import hs_pkg::*;
    logic        core_clk = 1'b0;
    logic        srst     = 1'b1;
    logic        open_cmd = 1'b1;
    logic        handle_closed, irq_pin, irq_out, irq_oe, led_drive, hid;
    hs_cfg_req_t req      = '0;
    hs_cfg_rsp_t rsp;
    logic [31:0] rd;
    logic        got;
    int          error_cnt = 0;
    int          check_count = 0;
    // 40 MHz clock
    always #12.5 core_clk = ~core_clk;
    hs_cap_regs dut_u (.core_clk(core_clk), .srst(srst), .cfg_req(req),
        .cfg_rsp(rsp), .handle_closed(handle_closed),
        .enumeration_irq_n_in(irq_pin), .enumeration_irq_n_out(irq_out),
        .enumeration_irq_n_oe(irq_oe), .led_drive(led_drive),
        .bridge_hidden(hid));
    hs_ejector_model sw_u (.open_cmd(open_cmd), .handle_closed(handle_closed),
        .irq_out(irq_out), .irq_oe(irq_oe), .irq_pin(irq_pin));
    task automatic chk(input string what, input logic [31:0] exp, seen);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s exp %h got %h", what, exp, seen);
        end
    endtask : chk
    // one-cycle strobe, ack polled a few edges since a hidden bridge is mute
    task automatic acc(input logic wr, input logic [5:0] a,
                       input logic [7:0] ctl);
        got = 1'b0;
        @(negedge core_clk);
        req <= '{1'b1, wr, a, 4'hB, {8'h00, ctl, 16'h0000}};
        @(negedge core_clk);
        req.req <= 1'b0;
        repeat (3) begin
            if (rsp.ack === 1'b1 && !got) begin
                got = 1'b1;
                rd = rsp.rdata;
            end
            @(negedge core_clk);
        end
    endtask : acc
    task automatic rd39(input logic [7:0] ctl);
        logic [31:0] want;
        want = {8'h00, ctl, HS_NEXT_PTR_VALUE, HS_CAP_ID_VALUE};
        acc(1'b0, HS_DW_HS, 8'h00);
        chk("ack", 1, got);
        chk("dword", want, rd);
    endtask : rd39
    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim
    // watchdog, far beyond the hundred or so cycles the tests need
    initial begin
        #20000;
        error_cnt++;
        end_sim;
    end
    // main sequence: reset with handle open, insert, then extract
    initial begin
        repeat (2) @(negedge core_clk);
        srst <= 1'b0;
        repeat (12) if (hid !== 1'b1) @(negedge core_clk);
        chk("hidden", 1, hid);
        acc(1'b0, HS_DW_HS, 8'h00);
        chk("hidden ack", 0, got);
        open_cmd <= 1'b0;
        repeat (12) if (irq_pin !== 1'b0) @(negedge core_clk);
        chk("hidden", 0, hid);
        chk("pin insert", 0, irq_pin);
        rd39(8'h90);
        acc(1'b0, HS_DW_PM, 8'h00);
        chk("pm ack", 1, got);
        chk("pm data", 0, rd);
        acc(1'b1, HS_DW_HS, 8'h00);
        rd39(8'h90);
        acc(1'b1, HS_DW_HS, 8'h02);
        chk("pin masked", 1, irq_pin);
        acc(1'b1, HS_DW_HS, 8'h00);
        chk("pin unmasked", 0, irq_pin);
        acc(1'b1, HS_DW_HS, 8'h80);
        chk("pin released", 1, irq_pin);
        acc(1'b1, HS_DW_HS, 8'h08);
        chk("led", 1, led_drive);
        rd39(8'h18);
        open_cmd <= 1'b1;
        repeat (12) if (irq_pin !== 1'b0) @(negedge core_clk);
        chk("pin extract", 0, irq_pin);
        rd39(8'h58);
        acc(1'b1, HS_DW_HS, 8'h48);
        rd39(8'h18);
        acc(1'b1, HS_DW_HS, 8'h00);
        chk("led", 0, led_drive);
        // reset again with the handle closed: insertion without hiding
        open_cmd <= 1'b0;
        srst     <= 1'b1;
        repeat (2) @(negedge core_clk);
        srst <= 1'b0;
        @(negedge core_clk);
        chk("reset pin", 1, irq_pin);
        chk("reset ack", 0, rsp.ack);
        repeat (12) if (irq_pin !== 1'b0) @(negedge core_clk);
        chk("closed hidden", 0, hid);
        rd39(8'h90);
        end_sim;
    end
endmodule : testbench
bind hs_cap_regs hs_props props_u (.core_clk(core_clk), .srst(srst),
    .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .handle_closed(handle_closed),
    .enumeration_irq_n_out(enumeration_irq_n_out),
    .enumeration_irq_n_oe(enumeration_irq_n_oe), .led_drive(led_drive),
    .bridge_hidden(bridge_hidden));
`default_nettype wire
